// file: design/spdif_rx_config_src_gate.sv
// receiver configuration registers, converter input gating, delay and mute
// assumes an apb master on clk, and sample strobes from the receiver on clk
// What this block does
// - converter mute bit soft-mutes converter output
// - seven-bit field sets extra filter delay samples
// - unlocked receiver clocks from fallback choice
// - ratio codes select 128, 256, 512 fs
// - auto de-emphasis follows received channel status
// - parity/biphase error: none, hold, zero
// - lock loss: none, hold, zeros, soft-mute
// - hard-mute bit zeroes receiver audio at once
// - pll reference from preambles or serial port
// - port code picks playback, aux, record, auxout
// - non-audio blocking bit stops converter input
// - compressed non-audio data is always blocked
// - validity blocking bit stops converter input
`timescale 1ns/1ps
`default_nettype none

module spdif_rx_config_src_gate #(
  parameter int SAMPLE_WIDTH = 24
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // receiver sample stream
  input  wire logic                    rxValid,
  input  wire logic [SAMPLE_WIDTH-1:0] rxSample,
  input  wire logic                    rxParityErr,
  input  wire logic                    rxValidityFlag,
  input  wire logic                    rxNonAudioFlag,
  input  wire logic                    rxCompressed,
  input  wire logic                    rxEmphasis,
  // pll lock, from the pll domain
  input  wire logic                    pllLocked,
  // converter input and output samples
  input  wire logic                    srcValid,
  input  wire logic [SAMPLE_WIDTH-1:0] srcSample,
  output logic                         srcInValid,
  output logic [SAMPLE_WIDTH-1:0]      srcInSample,
  output logic                         srcOutValid,
  output logic [SAMPLE_WIDTH-1:0]      srcOutSample,
  // control to clock and filter blocks
  output logic [6:0]                   firExtraDelay,
  output logic                         rxClkUseInternal,
  output logic [1:0]                   recoveredClockRatio,
  output logic                         deemphasisOn,
  output logic                         pllRefFromPort,
  output logic [1:0]                   pllRefPortSelect,
  // interrupt
  output logic                         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // apb register file

  localparam int EVT_W = rx_cfg_pkg::EVT_WIDTH;
  logic [7:0]           delayMute_ff, nxt_delayMute;   // converter delay and mute
  logic [7:0]           rxCfgOne_ff,  nxt_rxCfgOne;    // receiver config one
  logic [7:0]           rxCfgTwo_ff,  nxt_rxCfgTwo;    // receiver config two
  logic [EVT_W-1:0]     irqStat_ff,   nxt_irqStat;     // sticky events
  logic [EVT_W-1:0]     irqEn_ff,     nxt_irqEn;       // event enables
  logic [31:0]          prdata_ff,    nxt_prdata;      // read data
  logic                 pready_ff,    nxt_pready;      // one wait state
  logic                 pslverr_ff,   nxt_pslverr;     // unmapped answer
  logic [EVT_W-1:0]     evt;                           // this cycle's events

  // decode a word address to the register index; 4'hF means unmapped
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    if (a[1:0] != 2'h0 || a[7:6] != 2'h0)
      reg_index = 4'hF;
    else
      reg_index = a[5:2];
  endfunction

  logic        access;   // access phase edge where the answer is given
  logic [3:0]  idx;
  logic        lockedSync;

  always_comb begin
    access        = psel && penable && pready_ff;
    idx           = reg_index(paddr);
    nxt_delayMute = delayMute_ff;
    nxt_rxCfgOne  = rxCfgOne_ff;
    nxt_rxCfgTwo  = rxCfgTwo_ff;
    nxt_irqEn     = irqEn_ff;
    nxt_prdata    = prdata_ff;
    nxt_pslverr   = 1'b0;
    // answer one cycle into the access phase
    nxt_pready    = psel && penable && !pready_ff;
    // events set after a clear so that a same-cycle set wins
    nxt_irqStat   = irqStat_ff;
    if (access && pwrite && idx == rx_cfg_pkg::IDX_IRQ_CLEAR) begin
      nxt_irqStat = irqStat_ff & ~pwdata[EVT_W-1:0];
    end
    nxt_irqStat = nxt_irqStat | evt;
    if (nxt_pready) begin
      // read data and error prepared for the answering edge
      nxt_prdata  = 32'h0000_0000;
      unique case (idx)
        rx_cfg_pkg::IDX_DELAY_MUTE: nxt_prdata[7:0] = delayMute_ff;
        rx_cfg_pkg::IDX_RX_CFG_ONE: nxt_prdata[7:0] = rxCfgOne_ff;
        rx_cfg_pkg::IDX_RX_CFG_TWO: nxt_prdata[7:0] = rxCfgTwo_ff;
        rx_cfg_pkg::IDX_IRQ_STATUS: nxt_prdata[EVT_W-1:0] = irqStat_ff;
        rx_cfg_pkg::IDX_IRQ_ENABLE: nxt_prdata[EVT_W-1:0] = irqEn_ff;
        rx_cfg_pkg::IDX_IRQ_CLEAR:  nxt_prdata = 32'h0000_0000;
        rx_cfg_pkg::IDX_RX_STATE:   nxt_prdata[0] = lockedSync;
        default:                    nxt_pslverr = 1'b1;
      endcase
    end
    if (access && pwrite) begin
      // writes take effect only at the answering edge
      unique case (idx)
        rx_cfg_pkg::IDX_DELAY_MUTE: nxt_delayMute = pwdata[7:0];
        rx_cfg_pkg::IDX_RX_CFG_ONE: nxt_rxCfgOne  = pwdata[7:0];
        rx_cfg_pkg::IDX_RX_CFG_TWO: nxt_rxCfgTwo  = pwdata[7:0] & rx_cfg_pkg::MASK_RX_CFG_TWO;
        rx_cfg_pkg::IDX_IRQ_ENABLE: nxt_irqEn     = pwdata[EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // register the bus state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      delayMute_ff <= rx_cfg_pkg::RST_DELAY_MUTE;
      rxCfgOne_ff  <= rx_cfg_pkg::RST_RX_CFG_ONE;
      rxCfgTwo_ff  <= rx_cfg_pkg::RST_RX_CFG_TWO;
      irqStat_ff   <= '0;
      irqEn_ff     <= '0;
      prdata_ff    <= 32'h0000_0000;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
    end else begin
      delayMute_ff <= nxt_delayMute;
      rxCfgOne_ff  <= nxt_rxCfgOne;
      rxCfgTwo_ff  <= nxt_rxCfgTwo;
      irqStat_ff   <= nxt_irqStat;
      irqEn_ff     <= nxt_irqEn;
      prdata_ff    <= nxt_prdata;
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock synchroniser and receive path

  logic lockMeta_ff, lockSync_ff, lockPrev_ff;  // two-stage sync, then history
  assign lockedSync = lockSync_ff;

  // lock comes from the pll domain, so it is synchronised first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lockMeta_ff <= 1'b0;
      lockSync_ff <= 1'b0;
      lockPrev_ff <= 1'b0;
    end else begin
      lockMeta_ff <= pllLocked;
      lockSync_ff <= lockMeta_ff;
      lockPrev_ff <= lockSync_ff;
    end
  end

  logic [SAMPLE_WIDTH-1:0] lastGood_ff, nxt_lastGood;  // last valid sample
  logic [SAMPLE_WIDTH-1:0] rxOut_ff,    nxt_rxOut;     // to converter input
  logic                    rxOutV_ff,   nxt_rxOutV;
  logic [8:0]              lockGain_ff, nxt_lockGain;  // lock-loss fade gain
  logic [1:0]              errAct, lockAct;
  logic                    blocked;
  logic [SAMPLE_WIDTH-1:0] picked;
  logic [SAMPLE_WIDTH+8:0] scaled;

  always_comb begin
    errAct  = rxCfgOne_ff[rx_cfg_pkg::POS_ERR_ACT +: 2];
    lockAct = rxCfgOne_ff[rx_cfg_pkg::POS_LOCK_ACT +: 2];
    blocked = rxCompressed
           || (rxCfgTwo_ff[rx_cfg_pkg::POS_BLK_NONAUD] && rxNonAudioFlag)
           || (rxCfgTwo_ff[rx_cfg_pkg::POS_BLK_INVAL]  && rxValidityFlag);
    picked       = rxSample;
    nxt_lastGood = lastGood_ff;
    nxt_lockGain = lockGain_ff;
    if (rxParityErr) begin
      unique case (errAct)
        rx_cfg_pkg::ACT_HOLD: picked = lastGood_ff;
        rx_cfg_pkg::ACT_ZERO: picked = '0;
        default:              picked = rxSample;  // none, and reserved code
      endcase
    end
    if (!lockSync_ff) begin
      unique case (lockAct)
        rx_cfg_pkg::ACT_HOLD: picked = lastGood_ff;
        rx_cfg_pkg::ACT_ZERO: picked = '0;
        rx_cfg_pkg::ACT_SOFT: picked = lastGood_ff;
        default:              ;
      endcase
    end
    // fade the held sample while unlocked with the soft-mute lock-loss action
    if (rxValid) begin
      if (!lockSync_ff && lockAct == rx_cfg_pkg::ACT_SOFT)
        nxt_lockGain = (lockGain_ff > rx_cfg_pkg::GAIN_STEP) ?
                       9'(lockGain_ff - rx_cfg_pkg::GAIN_STEP) : 9'h000;
      else if (lockSync_ff)
        nxt_lockGain = rx_cfg_pkg::GAIN_UNITY;
    end
    scaled = $signed(picked) * $signed({1'b0, lockGain_ff});
    if (!lockSync_ff && lockAct == rx_cfg_pkg::ACT_SOFT)
      picked = scaled[SAMPLE_WIDTH+7:8];
    if (rxValid && lockSync_ff && !rxParityErr)
      nxt_lastGood = rxSample;
    if (rxCfgTwo_ff[rx_cfg_pkg::POS_HARD_MUTE])
      picked = '0;
    nxt_rxOut  = rxValid ? picked : rxOut_ff;
    nxt_rxOutV = rxValid && !blocked;
    // events: error, lock loss edge, blocked sample
    evt = '0;
    evt[rx_cfg_pkg::EVT_BIPHASE]   = rxValid && rxParityErr;
    evt[rx_cfg_pkg::EVT_LOCK_LOSS] = lockPrev_ff && !lockSync_ff;
    evt[rx_cfg_pkg::EVT_BLOCKED]   = rxValid && blocked;
  end

  // register the receive path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lastGood_ff <= '0;
      rxOut_ff    <= '0;
      rxOutV_ff   <= 1'b0;
      lockGain_ff <= rx_cfg_pkg::GAIN_UNITY;
    end else begin
      lastGood_ff <= nxt_lastGood;
      rxOut_ff    <= nxt_rxOut;
      rxOutV_ff   <= nxt_rxOutV;
      lockGain_ff <= nxt_lockGain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter output soft mute

  logic [8:0]              muteGain_ff, nxt_muteGain;  // output ramp gain
  logic [SAMPLE_WIDTH-1:0] srcOut_ff,   nxt_srcOut;
  logic                    srcOutV_ff,  nxt_srcOutV;
  logic [SAMPLE_WIDTH+8:0] srcScaled;

  always_comb begin
    nxt_muteGain = muteGain_ff;
    if (srcValid) begin
      if (delayMute_ff[rx_cfg_pkg::POS_SOFT_MUTE])
        nxt_muteGain = (muteGain_ff > rx_cfg_pkg::GAIN_STEP) ?
                       9'(muteGain_ff - rx_cfg_pkg::GAIN_STEP) : 9'h000;
      else
        nxt_muteGain = (muteGain_ff < 9'(rx_cfg_pkg::GAIN_UNITY - rx_cfg_pkg::GAIN_STEP)) ?
                       9'(muteGain_ff + rx_cfg_pkg::GAIN_STEP) : rx_cfg_pkg::GAIN_UNITY;
    end
    srcScaled   = $signed(srcSample) * $signed({1'b0, muteGain_ff});
    nxt_srcOut  = srcValid ? srcScaled[SAMPLE_WIDTH+7:8] : srcOut_ff;
    nxt_srcOutV = srcValid;
  end

  // register converter output and its ramp gain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      muteGain_ff <= rx_cfg_pkg::GAIN_UNITY;
      srcOut_ff   <= '0;
      srcOutV_ff  <= 1'b0;
    end else begin
      muteGain_ff <= nxt_muteGain;
      srcOut_ff   <= nxt_srcOut;
      srcOutV_ff  <= nxt_srcOutV;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs, each from a flip-flop

  logic [6:0] delay_ff;
  logic       intClk_ff, deemph_ff, refPort_ff, irq_ff, emphSeen_ff;  // emphasis of last sample
  logic [1:0] ratio_ff, portSel_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      delay_ff   <= 7'h00;
      intClk_ff  <= 1'b0;
      ratio_ff   <= rx_cfg_pkg::RATIO_128;
      deemph_ff  <= 1'b0;
      emphSeen_ff <= 1'b0;
      refPort_ff <= 1'b0;
      portSel_ff <= 2'h0;
      irq_ff     <= 1'b0;
    end else begin
      delay_ff   <= delayMute_ff[6:0];
      intClk_ff  <= !lockSync_ff && rxCfgOne_ff[rx_cfg_pkg::POS_FALLBACK];
      // ratio code; reserved code left to software
      ratio_ff   <= rxCfgOne_ff[rx_cfg_pkg::POS_RATIO +: 2];
      // emphasis flag taken with samples only, idle lines ignored
      emphSeen_ff <= rxValid ? rxEmphasis : emphSeen_ff;
      deemph_ff  <= rxCfgOne_ff[rx_cfg_pkg::POS_DEEMPH] && (rxValid ? rxEmphasis : emphSeen_ff);
      refPort_ff <= rxCfgTwo_ff[rx_cfg_pkg::POS_REF_PORT];
      portSel_ff <= rxCfgTwo_ff[rx_cfg_pkg::POS_PORT_SEL +: 2];
      irq_ff     <= |(nxt_irqStat & nxt_irqEn);
    end
  end

  assign pready              = pready_ff;
  assign prdata              = prdata_ff;
  assign pslverr             = pslverr_ff;
  assign srcInValid          = rxOutV_ff;
  assign srcInSample         = rxOut_ff;
  assign srcOutValid         = srcOutV_ff;
  assign srcOutSample        = srcOut_ff;
  assign firExtraDelay       = delay_ff;
  assign rxClkUseInternal    = intClk_ff;
  assign recoveredClockRatio = ratio_ff;
  assign deemphasisOn        = deemph_ff;
  assign pllRefFromPort      = refPort_ff;
  assign pllRefPortSelect    = portSel_ff;
  assign irq                 = irq_ff;
endmodule // spdif_rx_config_src_gate
`default_nettype wire

// file: design/rx_cfg_pkg.sv
// constants shared by the receiver configuration and converter gating block
// assumes a 250 MHz system clock and an APB register bus with 32-bit data
package rx_cfg_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [3:0]  IDX_DELAY_MUTE = 4'h8;
  localparam logic [3:0]  IDX_RX_CFG_ONE = 4'h9;
  localparam logic [3:0]  IDX_RX_CFG_TWO = 4'hA;
  localparam logic [3:0]  IDX_IRQ_STATUS = 4'hB;
  localparam logic [3:0]  IDX_IRQ_ENABLE = 4'hC;
  localparam logic [3:0]  IDX_IRQ_CLEAR  = 4'hD;
  localparam logic [3:0]  IDX_RX_STATE   = 4'hE;
  // register reset values
  localparam logic [7:0]  RST_DELAY_MUTE = 8'h00;
  localparam logic [7:0]  RST_RX_CFG_ONE = 8'h00;
  localparam logic [7:0]  RST_RX_CFG_TWO = 8'h00;
  // field positions
  localparam int          POS_SOFT_MUTE  = 7;
  localparam int          POS_FALLBACK   = 7;
  localparam int          POS_RATIO      = 5;
  localparam int          POS_DEEMPH     = 4;
  localparam int          POS_ERR_ACT    = 2;
  localparam int          POS_LOCK_ACT   = 0;
  localparam int          POS_HARD_MUTE  = 7;
  localparam int          POS_REF_PORT   = 6;
  localparam int          POS_PORT_SEL   = 4;
  localparam int          POS_BLK_NONAUD = 1;
  localparam int          POS_BLK_INVAL  = 0;
  // writable bits of the second receiver register (bits 3:2 reserved)
  localparam logic [7:0]  MASK_RX_CFG_TWO = 8'hF3;
  // interrupt status bit positions
  localparam int          EVT_BIPHASE    = 0;
  localparam int          EVT_LOCK_LOSS  = 1;
  localparam int          EVT_BLOCKED    = 2;
  localparam int          EVT_RESERVED   = 3;
  localparam int          EVT_WIDTH      = 4;
  // action codes for errors and lock loss
  localparam logic [1:0]  ACT_NONE       = 2'h0;
  localparam logic [1:0]  ACT_HOLD       = 2'h1;
  localparam logic [1:0]  ACT_ZERO       = 2'h2;
  localparam logic [1:0]  ACT_SOFT       = 2'h3;
  // recovered clock ratio codes
  localparam logic [1:0]  RATIO_128      = 2'h0;
  localparam logic [1:0]  RATIO_256      = 2'h1;
  localparam logic [1:0]  RATIO_512      = 2'h2;
  // soft mute ramp: one gain step per sample, from unity down to zero
  localparam int          GAIN_WIDTH     = 8;
  localparam logic [8:0]  GAIN_UNITY     = 9'h100;
  localparam logic [8:0]  GAIN_STEP      = 9'h008;
endpackage : rx_cfg_pkg

// file: verif/spdif_source_model.sv
// source model: one framed sample per bench request, flags ride along
// assumes requests at least two clk cycles apart, reset shared with dut
`timescale 1ns/1ps
`default_nettype none
module spdif_source_model (
  // clock, reset, bench request
  input  wire logic        clk, arst_n, req,
  input  wire logic [23:0] reqData,
  input  wire logic [4:0]  reqFlags,
  // sample stream into the receiver logic
  output logic             rxValid, rxParityErr, rxValidityFlag,
  output logic             rxNonAudioFlag, rxCompressed, rxEmphasis,
  output logic [23:0]      rxSample
);
  logic [4:0] flg;  // emphasis, compressed, nonaudio, validity, parity
  assign {rxEmphasis, rxCompressed, rxNonAudioFlag, rxValidityFlag, rxParityErr} = flg;
  // idle lines carry inverted data so a stale word never looks good
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {rxValid, flg, rxSample} <= '0;
    end else begin
      rxValid <= req;
      {flg, rxSample} <= req ? {reqFlags, reqData} : ~{flg, rxSample};
    end
  end
endmodule // spdif_source_model
`default_nettype wire

// file: verif/spdif_rx_config_src_gate_sva.sv
// checker for the receiver config block, bound to its top ports
// assumes apb with one wait state and one-cycle stream latency
`timescale 1ns/1ps
`default_nettype none
module spdif_rx_config_src_gate_sva (
  // clock and reset
  input wire logic        clk, arst_n,
  // apb
  input wire logic        psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // stream and controls
  input wire logic        rxValid, rxCompressed, rxValidityFlag, rxNonAudioFlag,
  input wire logic        srcValid, srcInValid, srcOutValid, pllRefFromPort,
  input wire logic [6:0]  firExtraDelay,
  input wire logic [1:0]  recoveredClockRatio, pllRefPortSelect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic wrDone;  // write landing at this edge
  assign wrDone = psel && penable && pready && pwrite && !pslverr;
  ////////////////////////////////////////////////////////////////////////////
  chk_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not one cycle into access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_unmapped_err: assert property (psel && penable && pready && (paddr[7:6] != 2'h0
    || paddr[1:0] != 2'h0 || paddr[5:2] < 4'h8 || paddr[5:2] == 4'hF) |-> pslverr)
    else $error("unmapped access without error");
  chk_delay_follow: assert property (
    wrDone && paddr == 8'h20 |-> ##2 firExtraDelay == $past(pwdata[6:0], 2))
    else $error("delay output differs from write");
  chk_ratio_follow: assert property (
    wrDone && paddr == 8'h24 |-> ##2 recoveredClockRatio == $past(pwdata[6:5], 2))
    else $error("ratio output differs from write");
  chk_ref_follow: assert property (
    wrDone && paddr == 8'h28 |-> ##2 {pllRefFromPort, pllRefPortSelect} == $past(pwdata[6:4], 2))
    else $error("reference select differs from write");
  chk_compressed_block: assert property (rxValid && rxCompressed |=> !srcInValid)
    else $error("compressed sample reached converter");
  chk_clean_pass: assert property (
    rxValid && !rxCompressed && !rxValidityFlag && !rxNonAudioFlag |=> srcInValid)
    else $error("clean sample not forwarded");
  chk_out_follow: assert property (srcValid |=> srcOutValid)
    else $error("converter sample lost");
  // main scenarios reached
  cover property (wrDone && paddr == 8'h28);
  cover property (rxValid && rxCompressed);
  cover property (pready && pslverr);
endmodule // spdif_rx_config_src_gate_sva
bind spdif_rx_config_src_gate spdif_rx_config_src_gate_sva chk_i (.clk, .arst_n, .psel,
  .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .rxValid, .rxCompressed,
  .rxValidityFlag, .rxNonAudioFlag, .srcValid, .srcInValid, .srcOutValid,
  .pllRefFromPort, .firExtraDelay, .recoveredClockRatio, .pllRefPortSelect);
`default_nettype wire

// file: verif/spdif_rx_config_src_gate_test.sv
// bench: apb register access, stream gating, mutes, interrupt
// assumes the source model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module spdif_rx_config_src_gate_test;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pllLocked = 1'b1, srcValid = 1'b0, req = 1'b0, slvErr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [23:0] srcSample = 24'h0, reqData = 24'h0, rxSample, srcInSample, srcOutSample;
  logic [4:0] reqFlags = 5'h00;
  logic pready, pslverr, irq, rxValid, rxParityErr, rxValidityFlag, rxNonAudioFlag;
  logic rxCompressed, rxEmphasis, srcInValid, srcOutValid, rxClkUseInternal;
  logic deemphasisOn, pllRefFromPort;
  logic [6:0] firExtraDelay;
  logic [1:0] recoveredClockRatio, pllRefPortSelect;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  // gating cases: register value, sample flags, pass bits
  logic [7:0] bCfg [7] = '{8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02};
  logic [4:0] bFlg [7] = '{5'h02, 5'h04, 5'h02, 5'h04, 5'h08, 5'h04, 5'h02};
  logic [6:0] bOk = 7'b1101100;
  spdif_rx_config_src_gate dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .rxValid, .rxSample, .rxParityErr, .rxValidityFlag,
    .rxNonAudioFlag, .rxCompressed, .rxEmphasis, .pllLocked, .srcValid, .srcSample,
    .srcInValid, .srcInSample, .srcOutValid, .srcOutSample, .firExtraDelay,
    .rxClkUseInternal, .recoveredClockRatio, .deemphasisOn, .pllRefFromPort,
    .pllRefPortSelect, .irq);
  spdif_source_model src (.clk, .arst_n, .req, .reqData, .reqFlags, .rxValid, .rxSample,
    .rxParityErr, .rxValidityFlag, .rxNonAudioFlag, .rxCompressed, .rxEmphasis);
  initial forever #2 clk = ~clk;
  // hang guard, well above the run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, request held until pready, then settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {rdat, slvErr} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    repeat (3) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // one receiver sample through the model, checked a cycle after it
  task automatic smp(input logic [4:0] f, input logic v, input logic [23:0] d, e);
    @(posedge clk);
    {req, reqFlags, reqData} <= {1'b1, f, d};
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(32'(srcInValid), 32'(v));
    if (v) chk(32'(srcInSample), 32'(e));
  endtask
  // k converter output samples of a fixed level
  task automatic outs(input int k);
    repeat (k) begin
      @(posedge clk);
      {srcValid, srcSample} <= {1'b1, 24'h100000};
      @(posedge clk);
      {srcValid, srcSample} <= {1'b0, 24'h0FFFFF};
    end
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h24, 32'h00);
    wr(8'h20, 32'hFF);
    rd(8'h20, 32'hFF);
    chk(32'(firExtraDelay), 32'h7F);
    wr(8'h28, 32'hFF);
    rd(8'h28, 32'hF3);
    apb(1'b0, 8'h3C, 32'h0);
    chk(32'(slvErr), 32'h1);
    // unaligned, out-of-range write is refused and lands nowhere
    apb(1'b1, 8'h61, 32'h00);
    chk(32'(slvErr), 32'h1);
    rd(8'h20, 32'hFF);
    // every port code and the ratio codes 0, 1 and 2
    for (int i = 0; i < 4; i++) begin
      wr(8'h28, {24'h0, 2'b01, 2'(i), 4'h0});
      chk(32'({pllRefFromPort, pllRefPortSelect}), 32'(4 + i));
      wr(8'h24, {25'h0, 2'(i % 3), 5'h00});
      chk(32'(recoveredClockRatio), 32'(i % 3));
    end
    // gating table, then hard mute
    for (int i = 0; i < 7; i++) begin
      wr(8'h28, {24'h0, bCfg[i]});
      smp(bFlg[i], bOk[i], 24'h00A5C3, 24'h00A5C3);
    end
    wr(8'h28, 32'h80);
    smp(5'h00, 1'b1, 24'h00A5C3, 24'h0);
    wr(8'h28, 32'h00);
    // error codes while locked, then lock-loss codes: none, hold, zero
    smp(5'h00, 1'b1, 24'h123456, 24'h123456);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) @(posedge clk) pllLocked <= 1'b0;
      wr(8'h24, i < 3 ? 32'(i) << 2 : 32'(i - 3));
      smp(i < 3 ? 5'h01 : 5'h00, 1'b1, 24'h654321,
          i % 3 == 0 ? 24'h654321 : i % 3 == 1 ? 24'h123456 : 24'h0);
    end
    // lock-loss soft mute: held sample first, then one ramp step down
    wr(8'h24, 32'h03);
    smp(5'h00, 1'b1, 24'h654321, 24'h123456);
    smp(5'h00, 1'b1, 24'h654321, 24'h11A2B3);
    wr(8'h24, 32'h80);
    chk(32'(rxClkUseInternal), 32'h1);
    rd(8'h38, 32'h0);
    @(posedge clk) pllLocked <= 1'b1;
    wr(8'h24, 32'h80);
    chk(32'(rxClkUseInternal), 32'h0);
    rd(8'h38, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wr(8'h24, 32'(i) << 4);
      smp(5'h10, 1'b1, 24'h000001, 24'h000001);
      repeat (2) @(negedge clk);
      chk(32'(deemphasisOn), 32'(i));
    end
    // soft mute ramps down and back up, starting unmuted
    wr(8'h20, 32'h00);
    outs(1);
    chk(32'(srcOutSample), 32'h100000);
    wr(8'h20, 32'h80);
    outs(16);
    chk(32'(srcOutSample != 0 && srcOutSample < 24'h100000), 32'h1);
    outs(24);
    chk(32'(srcOutSample), 32'h0);
    wr(8'h20, 32'h00);
    outs(40);
    chk(32'(srcOutSample), 32'h100000);
    // interrupt: raise, mask, clear
    wr(8'h34, 32'h0F);
    wr(8'h30, 32'h07);
    smp(5'h08, 1'b0, 24'h0, 24'h0);
    rd(8'h2C, 32'h4);
    chk(32'(irq), 32'h1);
    wr(8'h30, 32'h03);
    chk(32'(irq), 32'h0);
    rd(8'h34, 32'h0);
    wr(8'h34, 32'h04);
    rd(8'h2C, 32'h0);
    conclude();
  end
endmodule // spdif_rx_config_src_gate_test
`default_nettype wire
